// ==== testbench/ser_encode_top_asserts.sv ====
// Port level checks for the serializer front end.
// Assumes the single sys_clk domain and ser_encode_pkg drive codes.
`timescale 1ns/1ps
`default_nettype none
module ser_encode_checks
(
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       power_down_bar,
    input wire logic       parallel_clock_in,
    input wire logic       capture_edge_pin,
    input wire logic       output_swing_pin,
    input wire logic [2:0] deemphasis_pin,
    input wire logic       serial_out,
    input wire logic [1:0] drive_level,
    input wire logic [2:0] deemphasis_level,
    input wire logic       deemph_active,
    input wire logic       link_enabled,
    input wire logic       sleeping,
    input wire logic       override_active
);
    import ser_encode_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_pd_out;
        !power_down_bar ##1 !power_down_bar
            |-> drive_level == SWING_ZERO && !link_enabled;
    endproperty
    a_pd_out: assert property (p_pd_out)
        else $error("outputs not idle in power down");
    property p_pd_clr;
        !power_down_bar ##1 !power_down_bar |-> !override_active;
    endproperty
    a_pd_clr: assert property (p_pd_clr)
        else $error("override kept in power down");
    property p_keep;
        override_active && power_down_bar |=> override_active;
    endproperty
    a_keep: assert property (p_keep)
        else $error("override lost without power down");
    property p_swing;
        link_enabled && $past(link_enabled) && !override_active
            && $stable(override_active) && $stable(output_swing_pin)
            |-> drive_level == (output_swing_pin ? SWING_HIGH : SWING_STD);
    endproperty
    a_swing: assert property (p_swing)
        else $error("drive level does not follow swing pin");
    property p_deemph;
        link_enabled && $past(link_enabled) && !override_active
            && $stable(override_active) && $stable(deemphasis_pin)
            |-> deemphasis_level == ((deemphasis_pin > 3'h4) ?
                DEEMPH_OFF : deemphasis_pin);
    endproperty
    a_deemph: assert property (p_deemph)
        else $error("de-emphasis level does not follow pin");
    property p_demph_t;
        deemph_active |-> deemphasis_level != DEEMPH_OFF
            && $stable(serial_out);
    endproperty
    a_demph_t: assert property (p_demph_t)
        else $error("reduced drive on a transition bit");
    property p_sleep;
        link_enabled ##1 (power_down_bar && $stable(parallel_clock_in)) [*8]
            |-> ##[0:3] sleeping;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("stopped clock not detected");
    property p_lock;
        $fell(sleeping) |-> !link_enabled [*4];
    endproperty
    a_lock: assert property (p_lock)
        else $error("link resumed before lock");
    property p_frame;
        link_enabled && !override_active && $stable(capture_edge_pin)
            && capture_edge_pin && $rose(parallel_clock_in)
            |-> ##[2:3] (serial_out ##1 !serial_out);
    endproperty
    a_frame: assert property (p_frame)
        else $error("frame does not open with clock bits");
endmodule // ser_encode_checks
bind ser_encode_top ser_encode_checks u_ser_encode_checks
(
    .sys_clk(sys_clk), .rstn(rstn), .power_down_bar(power_down_bar),
    .parallel_clock_in(parallel_clock_in),
    .capture_edge_pin(capture_edge_pin),
    .output_swing_pin(output_swing_pin), .deemphasis_pin(deemphasis_pin),
    .serial_out(serial_out), .drive_level(drive_level),
    .deemphasis_level(deemphasis_level), .deemph_active(deemph_active),
    .link_enabled(link_enabled), .sleeping(sleeping),
    .override_active(override_active)
);
`default_nettype wire

// ==== testbench/ser_link_rx.sv ====
// Far end model: shifts the serial line in, one bit per sys_clk.
// Assumes bits are launched on sys_clk rising edges.
`timescale 1ns/1ps
`default_nettype none
module ser_link_rx
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        serial_in,
    output logic [27:0]      rx_bits
);
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn)
            rx_bits <= '0;
        else
            rx_bits <= {rx_bits[26:0], serial_in};
endmodule // ser_link_rx
`default_nettype wire

// ==== testbench/tb_ser_encode_top.sv ====
// Self-checking bench for the serializer front end.
// Assumes the far end model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb_ser_encode_top;
    import ser_encode_pkg::*;
    logic sys_clk = 1'b0, rstn = 1'b0, power_down_bar = 1'b1;
    logic parallel_clock_in = 1'b0, capture_edge_pin = 1'b1;
    logic output_swing_pin = 1'b0, cfg_write = 1'b0, pclk_run = 1'b0;
    logic cfg_capture_edge = 1'b0, cfg_output_swing = 1'b0;
    logic [2:0] deemphasis_pin = 3'h0, cfg_deemphasis = 3'h0, pcnt = 3'h0;
    logic [23:0] pixel_data = 24'h0;
    logic serial_out, deemph_active, link_enabled, sleeping, override_active;
    logic [1:0] drive_level;
    logic [2:0] deemphasis_level;
    logic [27:0] rx_bits;
    int errors = 0, n_compared = 0, n_cyc = 0, n_deemph = 0;
    always #20 sys_clk = ~sys_clk;
    ser_encode_top u_ser_encode_top (.sys_clk(sys_clk), .rstn(rstn),
        .power_down_bar(power_down_bar), .parallel_clock_in(parallel_clock_in),
        .pixel_data(pixel_data), .capture_edge_pin(capture_edge_pin),
        .output_swing_pin(output_swing_pin), .deemphasis_pin(deemphasis_pin),
        .cfg_write(cfg_write), .cfg_capture_edge(cfg_capture_edge),
        .cfg_output_swing(cfg_output_swing), .cfg_deemphasis(cfg_deemphasis),
        .serial_out(serial_out), .drive_level(drive_level),
        .deemphasis_level(deemphasis_level), .deemph_active(deemph_active),
        .link_enabled(link_enabled), .sleeping(sleeping),
        .override_active(override_active));
    ser_link_rx u_ser_link_rx (.sys_clk(sys_clk), .rstn(rstn),
        .serial_in(serial_out), .rx_bits(rx_bits));
    // Parallel clock of six system cycles; it simply freezes when stopped.
    // Held static when stopped.
    always @(posedge sys_clk)
    begin
        n_cyc++;
        if (deemph_active === 1'b1)
            n_deemph++;
        if (pclk_run)
        begin
            pcnt <= (pcnt == 3'h5) ? 3'h0 : pcnt + 3'h1;
            parallel_clock_in <= (pcnt < 3'h3);
            pixel_data <= pixel_data + 24'h030507;
        end
        if (n_cyc == 3000)
        begin
            errors++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [3:0] exp, got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_link();
        for (int i = 0; i < 200 && link_enabled !== 1'b1; i++)
            @(posedge sys_clk);
        #1;
        chk("link", 4'h1, {3'h0, link_enabled});
    endtask
    task automatic cfg_set(input logic edge_sel, swing, input logic [2:0] d);
        @(posedge sys_clk);
        cfg_write <= 1'b1;
        cfg_capture_edge <= edge_sel;
        cfg_output_swing <= swing;
        cfg_deemphasis <= d;
        @(posedge sys_clk);
        cfg_write <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    // Finds the selected edge as the design samples it, then reads the head.
    task automatic check_frame(input logic rise);
        logic prev;
        repeat (2) @(posedge sys_clk);
        prev = parallel_clock_in;
        @(posedge sys_clk);
        while (!(parallel_clock_in === rise && prev !== rise))
        begin
            prev = parallel_clock_in;
            @(posedge sys_clk);
        end
        repeat (5) @(posedge sys_clk);
        #1;
        chk("clock bits", 4'h2, {2'h0, rx_bits[3:2]});
        chk("balance pair", 4'h1, {3'h0, rx_bits[1] ^ rx_bits[0]});
    endtask
    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        pclk_run <= 1'b1;
        wait_link();
        chk("override", 4'h0, {3'h0, override_active});
        for (int c = 0; c < 8; c++)
        begin
            @(posedge sys_clk);
            deemphasis_pin <= c[2:0];
            output_swing_pin <= c[0];
            repeat (3) @(posedge sys_clk);
            #1;
            chk("deemph", (c > 4) ? 4'h0 : c[3:0],
                {1'b0, deemphasis_level});
            chk("drive", c[0] ? 4'h2 : 4'h1, {2'h0, drive_level});
        end
        chk("deemph seen", 4'h1, {3'h0, n_deemph != 0});
        @(posedge sys_clk);
        deemphasis_pin <= DEEMPH_OFF;
        output_swing_pin <= 1'b0;
        check_frame(1'b1);
        @(posedge sys_clk);
        capture_edge_pin <= 1'b0;
        check_frame(1'b0);
        cfg_set(1'b1, 1'b1, DEEMPH_6DB);
        chk("override", 4'h1, {3'h0, override_active});
        chk("drive", {2'h0, SWING_HIGH}, {2'h0, drive_level});
        chk("deemph", {1'b0, DEEMPH_6DB}, {1'b0, deemphasis_level});
        check_frame(1'b1);
        pclk_run <= 1'b0;
        repeat (20) @(posedge sys_clk);
        #1;
        chk("sleeping", 4'h1, {3'h0, sleeping});
        chk("link", 4'h0, {3'h0, link_enabled});
        chk("override", 4'h1, {3'h0, override_active});
        pclk_run <= 1'b1;
        wait_link();
        chk("drive", {2'h0, SWING_HIGH}, {2'h0, drive_level});
        check_frame(1'b1);
        @(posedge sys_clk);
        power_down_bar <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk("drive", {2'h0, SWING_ZERO}, {2'h0, drive_level});
        chk("link", 4'h0, {3'h0, link_enabled});
        chk("override", 4'h0, {3'h0, override_active});
        cfg_set(1'b1, 1'b1, DEEMPH_3DB);
        chk("override", 4'h0, {3'h0, override_active});
        @(posedge sys_clk);
        power_down_bar <= 1'b1;
        wait_link();
        chk("drive", {2'h0, SWING_STD}, {2'h0, drive_level});
        chk("deemph", {1'b0, DEEMPH_OFF}, {1'b0, deemphasis_level});
        check_frame(1'b0);
        close_out();
    end
endmodule // tb_ser_encode_top
`default_nettype wire

// ==== verilog/ser_encode_pkg.sv ====
// Constants shared by the serializer encode and power control block.
// Assumes a single 25 MHz system clock domain.
package ser_encode_pkg;
    localparam int          WORD_W        = 24;
    localparam int          PAYLOAD_W     = 26;
    localparam int          FRAME_W       = 28;
    localparam int          CLK_PERIOD_NS = 40;
    // Parallel clock stop threshold, in kHz.
    localparam int          STOP_FREQ_KHZ = 3000;
    // Longest edge gap of a 3 MHz clock, rounded down to system cycles.
    localparam int          STOP_GAP_CYC  =
        (1000000 / STOP_FREQ_KHZ) / CLK_PERIOD_NS;
    localparam int          LOCK_EDGES    = 4;
    localparam logic [22:0] SCR_SEED      = 23'h7fffff;
    localparam logic [2:0]  DEEMPH_OFF    = 3'h0;
    localparam logic [2:0]  DEEMPH_12DB   = 3'h1;
    localparam logic [2:0]  DEEMPH_9DB    = 3'h2;
    localparam logic [2:0]  DEEMPH_6DB    = 3'h3;
    localparam logic [2:0]  DEEMPH_3DB    = 3'h4;
    // Drive codes: 0 equal legs, 1 standard, 2 increased swing.
    localparam logic [1:0]  SWING_ZERO    = 2'h0;
    localparam logic [1:0]  SWING_STD     = 2'h1;
    localparam logic [1:0]  SWING_HIGH    = 2'h2;
    typedef enum logic [1:0] {ST_DOWN, ST_SLEEP, ST_LOCK, ST_RUN} pwr_state_t;
endpackage

// ==== verilog/ser_encode_top.sv ====
// Serializer front end: capture, encode, frame, shift out, power control.
// Assumes parallel clock and data are sampled as synchronous inputs and the
// serial shift runs at one bit per system clock.
`timescale 1ns/1ps
`default_nettype none
module ser_encode_top
(
    input  wire logic                                 sys_clk,
    input  wire logic                                 rstn,
    input  wire logic                                 power_down_bar,
    input  wire logic                                 parallel_clock_in,
    input  wire logic [ser_encode_pkg::WORD_W-1:0]    pixel_data,
    input  wire logic                                 capture_edge_pin,
    input  wire logic                                 output_swing_pin,
    input  wire logic [2:0]                           deemphasis_pin,
    input  wire logic                                 cfg_write,
    input  wire logic                                 cfg_capture_edge,
    input  wire logic                                 cfg_output_swing,
    input  wire logic [2:0]                           cfg_deemphasis,
    output logic                                      serial_out,
    output logic [1:0]                                drive_level,
    output logic [2:0]                                deemphasis_level,
    output logic                                      deemph_active,
    output logic                                      link_enabled,
    output logic                                      sleeping,
    output logic                                      override_active
);
    import ser_encode_pkg::*;

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic       ovr_r,    ovr_nxt;
    logic       edge_r,   edge_nxt;
    logic       swing_r,  swing_nxt;
    logic [2:0] demph_r,  demph_nxt;
    logic       pclk_d_r;
    pwr_state_t state_r,  state_nxt;

    logic       sel_edge;
    logic       sel_swing;
    logic [2:0] sel_demph;

    always_comb
    begin
        ovr_nxt   = ovr_r;
        edge_nxt  = edge_r;
        swing_nxt = swing_r;
        demph_nxt = demph_r;
        if (!power_down_bar)
        begin
            ovr_nxt   = 1'b0;
            edge_nxt  = 1'b0;
            swing_nxt = 1'b0;
            demph_nxt = DEEMPH_OFF;
        end
        else if (cfg_write)
        begin
            ovr_nxt   = 1'b1;
            edge_nxt  = cfg_capture_edge;
            swing_nxt = cfg_output_swing;
            demph_nxt = cfg_deemphasis > DEEMPH_3DB ? DEEMPH_OFF
                                                    : cfg_deemphasis;
        end
        // Sleep does not touch these registers.
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ovr_r   <= 1'b0;
            edge_r  <= 1'b0;
            swing_r <= 1'b0;
            demph_r <= DEEMPH_OFF;
        end
        else
        begin
            ovr_r   <= ovr_nxt;
            edge_r  <= edge_nxt;
            swing_r <= swing_nxt;
            demph_r <= demph_nxt;
        end
    end

    assign sel_edge  = ovr_r ? edge_r  : capture_edge_pin;
    assign sel_swing = ovr_r ? swing_r : output_swing_pin;
    assign sel_demph = ovr_r ? demph_r
                     : (deemphasis_pin > DEEMPH_3DB ? DEEMPH_OFF
                                                    : deemphasis_pin);

    // ****************************************************************
    // Clock watch and power state
    // ****************************************************************
    logic       cap_edge;
    logic [7:0] gap_r,    gap_nxt;
    logic [2:0] lock_r,   lock_nxt;
    logic       stopped;

    // Rising when high, falling when low.
    assign cap_edge = sel_edge ? (parallel_clock_in & ~pclk_d_r)
                               : (~parallel_clock_in & pclk_d_r);
    // Slower than 3 MHz counts as stopped.
    assign stopped  = gap_r >= 8'(STOP_GAP_CYC);

    always_comb
    begin
        gap_nxt   = cap_edge ? 8'h00 : (stopped ? gap_r : gap_r + 8'h01);
        lock_nxt  = lock_r;
        state_nxt = state_r;
        case (state_r)
            ST_DOWN:
            begin
                lock_nxt  = 3'h0;
                state_nxt = ST_LOCK;
            end
            ST_SLEEP:
            begin
                lock_nxt = 3'h0;
                if (cap_edge)
                begin
                    state_nxt = ST_LOCK;
                end
            end
            ST_LOCK:
            begin
                if (stopped)
                begin
                    state_nxt = ST_SLEEP;
                end
                else if (cap_edge)
                begin
                    lock_nxt = lock_r + 3'h1;
                    if (lock_r == 3'(LOCK_EDGES - 1))
                    begin
                        state_nxt = ST_RUN;
                    end
                end
            end
            ST_RUN:
            begin
                if (stopped)
                begin
                    state_nxt = ST_SLEEP;
                end
            end
            default:
            begin
                state_nxt = ST_DOWN;
            end
        endcase
        if (!power_down_bar)
        begin
            state_nxt = ST_DOWN;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r  <= ST_DOWN;
            gap_r    <= 8'h00;
            lock_r   <= 3'h0;
            pclk_d_r <= 1'b0;
        end
        else
        begin
            state_r  <= state_nxt;
            gap_r    <= gap_nxt;
            lock_r   <= lock_nxt;
            pclk_d_r <= parallel_clock_in;
        end
    end

    // ****************************************************************
    // Encode and shift
    // ****************************************************************
    logic [PAYLOAD_W-1:0] payload;
    logic signed [7:0]    disp_r,   disp_nxt, disp_new;
    logic [22:0]          scr_r,    scr_nxt;
    logic [FRAME_W-1:0]   shift_r,  shift_nxt;
    logic [4:0]           bit_r,    bit_nxt;
    logic                 sout_r,   sout_nxt;
    logic                 hold_r,   hold_nxt;
    logic                 run;

    ser_word_coder u_coder
    (
        .word_in       (pixel_data),
        .scr_state     (scr_r),
        .disparity     (disp_r),
        .payload       (payload),
        .disparity_nxt (disp_new)
    );

    assign run = (state_r == ST_RUN);

    always_comb
    begin
        disp_nxt  = disp_r;
        scr_nxt   = scr_r;
        shift_nxt = shift_r;
        bit_nxt   = bit_r;
        sout_nxt  = 1'b0;
        hold_nxt  = 1'b0;
        if (run && cap_edge)
        begin
            shift_nxt = {1'b1, 1'b0, payload};
            bit_nxt   = 5'(FRAME_W);
            disp_nxt  = disp_new;
            scr_nxt   = {scr_r[21:0], scr_r[22] ^ scr_r[17]};
        end
        else if (run && bit_r != 5'h00)
        begin
            shift_nxt = {shift_r[FRAME_W-2:0], 1'b0};
            bit_nxt   = bit_r - 5'h01;
        end
        if (run)
        begin
            sout_nxt = bit_r != 5'h00 ? shift_r[FRAME_W-1] : sout_r;
            // Reduced drive after one stable bit.
            hold_nxt = (sout_nxt == sout_r) && sel_demph != DEEMPH_OFF;
        end
        else if (!power_down_bar)
        begin
            disp_nxt = 8'sh00;
            scr_nxt  = SCR_SEED;
            bit_nxt  = 5'h00;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            disp_r  <= 8'sh00;
            scr_r   <= SCR_SEED;
            shift_r <= '0;
            bit_r   <= 5'h00;
            sout_r  <= 1'b0;
            hold_r  <= 1'b0;
        end
        else
        begin
            disp_r  <= disp_nxt;
            scr_r   <= scr_nxt;
            shift_r <= shift_nxt;
            bit_r   <= bit_nxt;
            sout_r  <= sout_nxt;
            hold_r  <= hold_nxt;
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            serial_out       <= 1'b0;
            drive_level      <= SWING_ZERO;
            deemphasis_level <= DEEMPH_OFF;
            deemph_active    <= 1'b0;
            link_enabled     <= 1'b0;
            sleeping         <= 1'b0;
            override_active  <= 1'b0;
        end
        else
        begin
            serial_out       <= sout_nxt;
            // Zero differential when down; swing choice.
            drive_level      <= !power_down_bar ? SWING_ZERO
                              : (sel_swing ? SWING_HIGH : SWING_STD);
            deemphasis_level <= sel_demph;
            deemph_active    <= hold_nxt;
            link_enabled     <= (state_nxt == ST_RUN);
            sleeping         <= (state_nxt == ST_SLEEP);
            override_active  <= ovr_nxt;
        end
    end
endmodule // ser_encode_top
`default_nettype wire

// ==== verilog/ser_word_coder.sv ====
// Combinational three step coder: scramble, DC balance, shuffle.
// Assumes the caller registers the result and owns the scrambler state.
`timescale 1ns/1ps
`default_nettype none
module ser_word_coder
(
    input  wire logic [ser_encode_pkg::WORD_W-1:0]    word_in,
    input  wire logic [22:0]                          scr_state,
    input  wire logic signed [7:0]                    disparity,
    output logic [ser_encode_pkg::PAYLOAD_W-1:0]      payload,
    output logic signed [7:0]                         disparity_nxt
);
    import ser_encode_pkg::*;

    logic [WORD_W-1:0] scrambled;
    logic [WORD_W-1:0] balanced;
    logic              invert;
    logic signed [7:0] ones_bal;

    function automatic logic signed [7:0] balance(input logic [WORD_W-1:0] w);
        logic signed [7:0] acc;
        acc = 8'sh00;
        for (int i = 0; i < WORD_W; i++)
        begin
            acc = w[i] ? acc + 8'sh01 : acc - 8'sh01;
        end
        return acc;
    endfunction

    always_comb
    begin
        scrambled = word_in ^ {scr_state, scr_state[22]};
        invert    = (balance(scrambled) > 8'sh00) == (disparity > 8'sh00)
                    && balance(scrambled) != 8'sh00;
        balanced  = invert ? ~scrambled : scrambled;
        ones_bal  = balance(balanced);
        disparity_nxt = disparity + ones_bal + (invert ? 8'sh01 : -8'sh01);
        for (int i = 0; i < 12; i++)
        begin
            payload[2*i]   = balanced[i];
            payload[2*i+1] = balanced[i+12];
        end
        payload[24] = invert;
        payload[25] = ~invert;
    end
endmodule // ser_word_coder
`default_nettype wire
